//--- kmp_pkg.sv
// Package with constants and carrier types for the keyer message playback control.
package kmp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  // Contacts must stay put this long before a change is believed.
  localparam int unsigned DEBOUNCE_US = 5;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  // The power-up dash strap is judged once, after two debounce intervals.
  localparam int unsigned STRAP_CYCLES = 2 * DEBOUNCE_CYCLES;
  localparam int unsigned ARM_WINDOW_MS = 1000;
  localparam int unsigned ARM_WINDOW_CYCLES = CLK_HZ / 1000 * ARM_WINDOW_MS;
  localparam int unsigned MSG_MAX_CHARS = 63;
  localparam int unsigned CHAR_IDX_W = 6;

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEN1 = 8'h08;
  localparam logic [7:0] ADDR_LEN2 = 8'h0C;
  localparam logic [7:0] ADDR_CHAR = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {KMP_IDLE, KMP_SELECT, KMP_ARM, KMP_PLAY, KMP_GAP, KMP_SPEED} kmp_state_e;

  typedef struct packed {
    logic dotN;
    logic dashN;
    logic selectN;
  } kmp_pins_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } kmp_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } kmp_apb_rsp_s;

endpackage

//--- kmp_playback_ctrl.sv
// Message playback start, abort and straight key control for a morse keyer.
`timescale 1ns/1ps

// Behaviour
// - Button held: dash picks 1, dot picks 2
// - Paddle mode: empty slot on release enters speed mode
// - Either paddle closed aborts running playback
// - During playback, paddles sampled only in character gaps
// - Dash grounded at power-up: straight key mode
// - Straight key mode allows only message 1
// - Straight key: dot within 1 s plays 1
// - Tip is dot, ring dash, low closed
// - Paddle assignment fixed, no swap option
// - Each slot holds up to 63 characters
module kmp_playback_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // Jack and button pins, low when closed
  input wire kmp_pkg::kmp_pins_s pins,
  // Character engine handshake
  input wire logic charGap,
  input wire logic charDone,
  output logic charStart,
  output logic [kmp_pkg::CHAR_IDX_W-1:0] charIndex,
  // Keying and mode outputs
  output logic keyOut,
  output logic playing,
  output logic playSlot,
  output logic speedMode,
  output logic straightMode,
  // Register bus
  input wire kmp_pkg::kmp_apb_req_s apbReq,
  output kmp_pkg::kmp_apb_rsp_s apbRsp
);
  import kmp_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers and debouncers
  // ---------------------------------------------------------------
  // The jack contacts and the button are asynchronous to the clock.
  // Each passes two flip-flops before anything reads it, so a change
  // that lands near an edge cannot split into two views of the pin.
  // Only the second stage feeds the debouncers and the strap logic.
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] closed;
  logic [2:0] closedQ;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      syncA <= 3'h7;
      syncB <= 3'h7;
    end else if (clkEn) begin
      syncA <= {pins.dotN, pins.dashN, pins.selectN};
      syncB <= syncA;
    end
  end

  // One debouncer per contact. The counter restarts whenever the pin
  // agrees with the accepted level, so only an unbroken run of the new
  // level as long as the debounce interval moves the accepted level.
  // Contact bounce shorter than that interval is ignored.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      logic [22:0] cnt;
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          cnt <= 23'h0;
          closed[gi] <= 1'b0;
        end else if (clkEn) begin
          if (!syncB[gi] == closed[gi]) begin
            cnt <= 23'h0;
          end else if (cnt == 23'(DEBOUNCE_CYCLES - 1)) begin
            cnt <= 23'h0;
            closed[gi] <= !syncB[gi];
          end else begin
            cnt <= cnt + 23'h1;
          end
        end
      end
    end
  endgenerate

  // Fixed tip/ring roles; no swap path exists.
  logic dotClosed;
  logic dashClosed;
  logic selClosed;
  assign dotClosed = closed[2];
  assign dashClosed = closed[1];
  assign selClosed = closed[0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      closedQ <= 3'h0;
    end else if (clkEn) begin
      closedQ <= closed;
    end
  end

  // Edge detection works on the debounced levels. The delayed copy
  // resets to open, which is the idle level of every contact, so no
  // false press or release is seen as reset ends.
  logic selRelease;
  logic dotPress;
  assign selRelease = closedQ[0] && !selClosed;
  assign dotPress = dotClosed && !closedQ[2];

  // ---------------------------------------------------------------
  // Power-up straight key detection
  // ---------------------------------------------------------------
  // The dash contact is judged once, at a fixed point counted from reset,
  // by which time a contact grounded since power-up has been accepted as
  // closed. A dash press later in the run therefore never changes the mode.
  // The mode then holds until the next reset.
  logic strapDone;
  logic [23:0] strapCnt;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapCnt <= '0;
    end else if (clkEn && !strapDone) begin
      strapCnt <= strapCnt + 24'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapDone <= 1'b0;
      straightMode <= 1'b0;
    end else if (clkEn && !strapDone && strapCnt == 24'(STRAP_CYCLES - 1)) begin
      strapDone <= 1'b1;
      straightMode <= dashClosed;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [CHAR_IDX_W-1:0] len1;
  logic [CHAR_IDX_W-1:0] len2;
  logic wrEn;
  logic rdEn;
  assign wrEn = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdEn = apbReq.psel && apbReq.penable && !apbReq.pwrite;

  // Message lengths are written by software over the register bus.
  // Every access completes in its first access cycle, with no wait
  // state. A length above the slot capacity is stored as the capacity,
  // so playback can never run past the end of a slot.
  // A length of zero marks the slot as empty.
  function automatic logic [CHAR_IDX_W-1:0] clampLen(input logic [31:0] v);
    clampLen = (v > 32'(MSG_MAX_CHARS)) ? CHAR_IDX_W'(MSG_MAX_CHARS) : v[CHAR_IDX_W-1:0];
  endfunction

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      len1 <= '0;
      len2 <= '0;
    end else if (clkEn && wrEn) begin
      if (apbReq.paddr == ADDR_LEN1) begin
        len1 <= clampLen(apbReq.pwdata);
      end
      if (apbReq.paddr == ADDR_LEN2) begin
        len2 <= clampLen(apbReq.pwdata);
      end
    end
  end

  logic known;
  logic [31:0] rdData;
  assign known = apbReq.paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_LEN1, ADDR_LEN2, ADDR_CHAR};

  // Read data is captured in the setup cycle, so it already stands
  // when the access cycle completes. It holds until the next read
  // setup. Unmapped addresses read as zero.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData <= 32'h0;
    end else if (clkEn && apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      unique case (apbReq.paddr)
        ADDR_STATUS: rdData <= {26'h0, playSlot, speedMode, straightMode, playing, dashClosed, dotClosed};
        ADDR_LEN1: rdData <= {26'h0, len1};
        ADDR_LEN2: rdData <= {26'h0, len2};
        ADDR_CHAR: rdData <= {26'h0, charIndex};
        default: rdData <= 32'h0;
      endcase
    end
  end

  assign apbRsp = '{pready: 1'b1, pslverr: (wrEn || rdEn) && !known, prdata: rdData};

  // ---------------------------------------------------------------
  // Playback state machine
  // ---------------------------------------------------------------
  // IDLE waits for the button. In paddle mode a held button leads to
  // SELECT, where the latest paddle picks the slot, dash over dot while both are closed; message 1 is the
  // default. Releasing the button starts playback, or enters code speed
  // adjustment when the picked slot is empty. In straight key mode the
  // button release opens the ARM window instead. PLAY requests one
  // character at a time; GAP waits between characters and is the only
  // place where the paddles can end playback early. SPEED is left by a
  // control register write with bit 0 set.
  kmp_state_e state;
  logic pickSlot;
  logic [27:0] armCnt;
  logic speedExit;
  assign speedExit = wrEn && apbReq.paddr == ADDR_CTRL && apbReq.pwdata[0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= KMP_IDLE;
      pickSlot <= 1'b0;
      playSlot <= 1'b0;
      charIndex <= '0;
      armCnt <= '0;
    end else if (clkEn) begin
      unique case (state)
        KMP_IDLE: begin
          pickSlot <= 1'b0;
          if (straightMode && selRelease) begin
            armCnt <= '0;
            state <= KMP_ARM;
          end else if (!straightMode && selClosed) begin
            state <= KMP_SELECT;
          end
        end
        KMP_SELECT: begin
          if (dashClosed) begin
            pickSlot <= 1'b0;
          end else if (dotClosed) begin
            pickSlot <= 1'b1;
          end
          if (!selClosed) begin
            playSlot <= pickSlot;
            charIndex <= '0;
            if ((pickSlot ? len2 : len1) == '0) begin
              state <= KMP_SPEED;
            end else begin
              state <= KMP_PLAY;
            end
          end
        end
        // Only message 1 can be reached here, because the key drives the
        // dot contact. A dot press with an empty slot, or no press within
        // the window, returns to IDLE.
        KMP_ARM: begin
          armCnt <= armCnt + 28'h1;
          if (dotPress && len1 != '0) begin
            playSlot <= 1'b0;
            charIndex <= '0;
            state <= KMP_PLAY;
          end else if (armCnt == 28'(ARM_WINDOW_CYCLES - 1) || dotPress) begin
            state <= KMP_IDLE;
          end
        end
        KMP_PLAY: begin
          if (charDone) begin
            charIndex <= charIndex + CHAR_IDX_W'(1);
            state <= KMP_GAP;
          end
        end
        // A paddle closed outside the gap is not acted on, so the operator
        // must hold it until the engine reports the gap between characters.
        // The message ends once every stored character has been sent.
        KMP_GAP: begin
          if (charGap && (dotClosed || dashClosed)) begin
            state <= KMP_IDLE;
          end else if (charIndex == (playSlot ? len2 : len1)) begin
            state <= KMP_IDLE;
          end else if (charGap) begin
            state <= KMP_PLAY;
          end
        end
        KMP_SPEED: begin
          if (speedExit) begin
            state <= KMP_IDLE;
          end
        end
      endcase
    end
  end

  assign charStart = state == KMP_PLAY;
  assign playing = state == KMP_PLAY || state == KMP_GAP;
  assign speedMode = state == KMP_SPEED;

  // ---------------------------------------------------------------
  // Straight key pass-through
  // ---------------------------------------------------------------
  // In straight key mode the dot contact keys the transmitter directly.
  // While a stored message plays the key is not passed through, so the
  // two keying sources overlap only in the first playback cycle, while keyOut
  // still holds the dot press that started it. The output is registered so it
  // carries no decode glitches.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      keyOut <= 1'b0;
    end else if (clkEn) begin
      keyOut <= straightMode && !playing && dotClosed;
    end
  end

endmodule

//--- kmp_checker.sv
// Concurrent checks on the playback control ports.
`timescale 1ns/1ps
module kmp_checker
  import kmp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  // Engine and mode signals
  input wire logic charGap,
  input wire logic charStart,
  input wire logic keyOut,
  input wire logic playing,
  input wire logic playSlot,
  input wire logic speedMode,
  input wire logic straightMode,
  // Register bus
  input wire kmp_pkg::kmp_apb_req_s apbReq,
  input wire kmp_pkg::kmp_apb_rsp_s apbRsp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_start_in_play: assert property (charStart |-> playing) else $error("char request outside playback");
  chk_end_in_gap: assert property ($fell(playing) |-> !$past(charStart)) else $error("playback left mid char");
  chk_speed_excl: assert property (!(speedMode && playing)) else $error("speed mode while playing");
  chk_key_straight: assert property (keyOut |-> straightMode) else $error("keying outside straight mode");
  chk_straight_sticky: assert property ($past(straightMode) |-> straightMode) else $error("straight mode lost");
  chk_slot_one_only: assert property (playing && straightMode |-> !playSlot) else $error("slot 2 in straight");
  chk_slot_held: assert property (playing && $past(playing) |-> $stable(playSlot)) else $error("slot moved");
  chk_freeze_hold: assert property (!clkEn |=> $stable({playing, straightMode})) else $error("state moved frozen");
  chk_bus_ready: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready) else $error("bus wait state");
  chk_bus_err: assert property (apbReq.psel && apbReq.penable && apbReq.paddr > 8'h10 |-> apbRsp.pslverr)
    else $error("unmapped access without error");
  cov_play: cover property ($rose(playing));
  cov_speed: cover property ($rose(speedMode));
  cov_err: cover property (apbRsp.pslverr);
endmodule

bind kmp_playback_ctrl kmp_checker u_chk (.clock(clock), .rstn(rstn), .clkEn(clkEn), .charGap(charGap),
  .charStart(charStart), .keyOut(keyOut), .playing(playing), .playSlot(playSlot), .speedMode(speedMode),
  .straightMode(straightMode), .apbReq(apbReq), .apbRsp(apbRsp));

//--- kmp_operator.sv
// Operator model: paddle contacts and select button, each closing to ground.
`timescale 1ns/1ps
module kmp_operator (
  // Clock
  input wire logic clock,
  // Contacts, pulled up when open
  output kmp_pkg::kmp_pins_s pins
);
  import kmp_pkg::*;
  initial pins = '1;
  // Closes the chosen contacts for a number of cycles, then lets them float back high.
  task automatic tap(input logic dot, input logic dash, input logic sel, input int n);
    @(posedge clock);
    pins <= '{dotN: !dot, dashN: !dash, selectN: !sel};
    repeat (n) @(posedge clock);
    pins <= '1;
  endtask
endmodule

//--- tb_top.sv
// Self-checking testbench for the playback control.
`timescale 1ns/1ps
module tb_top;
  import kmp_pkg::*;
  logic clock, rstn, clkEn, charGap, charDone, charStart, keyOut, playing, playSlot, speedMode, straightMode;
  logic [CHAR_IDX_W-1:0] charIndex;
  kmp_pins_s pins;
  kmp_apb_req_s apbReq;
  kmp_apb_rsp_s apbRsp;
  int n_fail, total_checks, cycles;
  logic [31:0] rd, st;
  logic err;
  kmp_operator u_op (.clock(clock), .pins(pins));
  kmp_playback_ctrl u_dut (.clock(clock), .rstn(rstn), .clkEn(clkEn), .pins(pins), .charGap(charGap),
    .charDone(charDone), .charStart(charStart), .charIndex(charIndex), .keyOut(keyOut), .playing(playing),
    .playSlot(playSlot), .speedMode(speedMode), .straightMode(straightMode), .apbReq(apbReq), .apbRsp(apbRsp));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    @(posedge clock);
    while (apbRsp.pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
  endtask
  task automatic s_reset();
    apb(0, ADDR_STATUS, 0);
    check(rd[5:2], 0);
    apb(0, ADDR_CHAR, 0);
    check(rd, 0);
  endtask
  task automatic s_lengths();
    apb(1, ADDR_LEN1, 32'h46);
    apb(0, ADDR_LEN1, 0);
    check(rd, 32'h3F);
    apb(1, ADDR_LEN2, 32'h3F);
    apb(0, ADDR_LEN2, 0);
    check(rd, 32'h3F);
    check(err, 0);
  endtask
  task automatic s_unmapped();
    apb(1, 8'h20, 32'hFFFF_FFFF);
    check(err, 1);
    apb(0, 8'h20, 0);
    check({err, rd}, {1'b1, 32'h0});
  endtask
  task automatic s_glitch();
    apb(0, ADDR_STATUS, 0);
    st = rd;
    charGap <= 1'b1;
    clkEn <= 1'b0;
    u_op.tap(1, 1, 1, 20);
    clkEn <= 1'b1;
    u_op.tap(1, 1, 1, 400);
    apb(0, ADDR_STATUS, 0);
    check(rd, st);
    check(playing, 0);
    check(speedMode, 0);
  endtask
  task automatic s_play();
    repeat (STRAP_CYCLES + 10) @(posedge clock);
    check(straightMode, 0);
    u_op.tap(0, 1, 1, 1100);
    repeat (1100) @(posedge clock);
    @(negedge clock);
    check(playing, 1);
    check(playSlot, 0);
    check(charStart, 1);
    check(charIndex, 0);
    @(posedge clock);
    charDone <= 1'b1;
    @(posedge clock);
    charDone <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(charIndex, 1);
    check(playing, 1);
    @(posedge clock);
    charGap <= 1'b0;
    charDone <= 1'b1;
    @(posedge clock);
    charDone <= 1'b0;
    u_op.tap(1, 0, 0, 1100);
    @(negedge clock);
    check(playing, 1);
    @(posedge clock);
    charGap <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(playing, 0);
    check(keyOut, 0);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    rstn = 0;
    clkEn = 1;
    charGap = 0;
    charDone = 0;
    apbReq = '0;
    n_fail = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    rstn <= 1;
    s_reset();
    s_lengths();
    s_unmapped();
    s_glitch();
    s_play();
    results();
  end
endmodule
